// ==== rtl/bit_sync_hdlc_receiver.sv ====
// receive section of a bit-synchronous framed line interface
// assumes modem clock and data are asynchronous to clk_i and much slower
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_rx_consts.svh"

// Functional notes
// - receive enable cleared holds all receive timing and control in reset
// - a flag partly received before enabling is never recognized
// - flag recognized at its eighth bit puts receiver into framed state
// - while framed the shift register takes one bit per bit time, except at an inserted zero
// - an inserted zero clocks neither shift register nor check register
// - flag characters never reach the receive buffer
// - each completed message character loads buffer and sets char ready
// - first delivered character carries start-of-message bit 8
// - ready is set on the same edge as the load; overrun tests the prior ready, so load alone gives no overrun
// - software reads the buffer to accept; the read clears char ready
// - loading while char ready still set raises receive overrun
// - secondary match sets receive active and withholds the address char
// - secondary mode compares first char with parameter bits 0-7
// - in primary mode an address-like character is delivered normally
// - with checking on, accumulation starts with the address character
// - every character between flags feeds the check when enabled, except while hunting after a secondary address miss
// - the two check characters are delivered as ordinary final data
// - closing flag loads buffer with end-of-message bit set
// - after closing flag clear message and active, set end seen, stay framed
// - at closing flag raise check error if checking is enabled and accumulated check is bad
module bit_sync_hdlc_receiver (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [3:0]  avm_address_i,
  input  wire logic        avm_read_i,
  input  wire logic        avm_write_i,
  input  wire logic [31:0] avm_writedata_i,
  input  wire logic [3:0]  avm_byteenable_i,
  output logic      [31:0] avm_readdata_o,
  output logic             avm_waitrequest_o,
  input  wire logic        rx_clk_i,
  input  wire logic        rx_data_i
);
  localparam int CB = `CHAR_BITS;

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction : is_reg

  // bus side state
  logic [2:0]          ctrl_reg;
  hdlc_rx_pkg::char_t  param_reg;
  logic                waitreq_reg;
  logic [31:0]         rdata_reg;

  // link synchronisers
  logic                rxc_s1, rxc_s2, rxc_s3;
  logic                rxd_s1, rxd_s2;

  // receive state
  logic                framed_reg;
  logic                hunt_reg;
  logic                lead_zero_reg;
  logic [2:0]          ones_reg;
  logic [2:0]          cnt_reg;
  hdlc_rx_pkg::char_t  shift_reg;
  logic                msg_reg;
  logic                active_reg;
  logic [3:0]          en_bits_reg;
  hdlc_rx_pkg::rxbuf_t buf_reg;
  logic                ready_reg;
  logic                overrun_reg;
  logic                end_reg;
  logic                err_reg;
  hdlc_rx_pkg::crc_t   crc_snap_reg;
  hdlc_rx_pkg::crc_t   crc_next;

  // decode
  wire rx_en    = ctrl_reg[`CTRL_EN_BIT];
  wire secondary_station_mode = ctrl_reg[`CTRL_SEC_BIT];
  wire chk_en   = ctrl_reg[`CTRL_CHK_BIT];
  wire bus_req  = avm_read_i | avm_write_i;
  wire rd_take  = avm_read_i & waitreq_reg;
  wire wr_go    = avm_write_i & ~waitreq_reg & avm_byteenable_i[0];
  wire buf_read = rd_take & is_reg(avm_address_i, `RX_OFF_BUF);
  wire wr_ctrl  = wr_go & is_reg(avm_address_i, `RX_OFF_CTRL);
  wire wr_param = wr_go & is_reg(avm_address_i, `RX_OFF_PARAM);
  wire wr_stat  = wr_go & is_reg(avm_address_i, `RX_OFF_STAT);
  wire clr_ovr  = wr_stat & avm_writedata_i[`STAT_OVR_BIT];
  wire clr_end  = wr_stat & avm_writedata_i[`STAT_END_BIT];
  wire clr_err  = wr_stat & avm_writedata_i[`STAT_ERR_BIT];

  wire        bit_en     = rx_en & rxc_s2 & ~rxc_s3;
  wire        rx_bit     = rxd_s2;
  wire        stuffed    = framed_reg & ~rx_bit & (ones_reg == `STUFF_ONES);
  wire        flag_hit   = bit_en & ~rx_bit & (ones_reg == `FLAG_ONES) & lead_zero_reg;
  wire        abort_hit  = bit_en & rx_bit & (ones_reg == `FLAG_ONES);
  wire        shift_en   = bit_en & framed_reg & ~stuffed;
  wire        data_bit   = shift_en & ~flag_hit & ~abort_hit;
  wire        count_full = cnt_reg == 3'(CB - 1);
  wire        char_done  = data_bit & count_full & ~hunt_reg;
  wire [7:0]  new_char   = {rx_bit, shift_reg[7:1]};
  wire        first_char = char_done & ~active_reg;
  wire        addr_ok    = new_char == param_reg;
  wire        sec_match  = first_char & secondary_station_mode & addr_ok;
  wire        sec_miss   = first_char & secondary_station_mode & ~addr_ok;
  wire        load_data  = char_done & (active_reg | ~secondary_station_mode);
  wire        close_hit  = flag_hit & msg_reg;
  wire        load_buf   = load_data | close_hit;
  wire        crc_bad    = crc_snap_reg != `CRC_GOOD;
  wire [6:0]  stat_w     = {framed_reg, err_reg, end_reg, msg_reg, active_reg,
                            overrun_reg, ready_reg};
  wire [31:0] rd_mux     =
    is_reg(avm_address_i, `RX_OFF_CTRL)  ? {29'h0, ctrl_reg}  :
    is_reg(avm_address_i, `RX_OFF_PARAM) ? {24'h0, param_reg} :
    is_reg(avm_address_i, `RX_OFF_STAT)  ? {25'h0, stat_w}    :
    is_reg(avm_address_i, `RX_OFF_BUF)   ? {22'h0, buf_reg}   : 32'h0;

  // check register restarts at every flag, so it begins with the address
  rx_check_crc u_crc (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .clear_i    (~rx_en | flag_hit),
    .step_i     (data_bit & chk_en & ~hunt_reg),
    .bit_i      (rx_bit),
    .crc_next_o (crc_next)
  );

  // Avalon-MM slave: one wait cycle, then the answer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) waitreq_reg <= 1'b1;
    else waitreq_reg <= ~(bus_req & waitreq_reg);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rdata_reg <= 32'h0;
    else if (rd_take) rdata_reg <= rd_mux;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg  <= `CTRL_RST;
      param_reg <= `PARAM_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= avm_writedata_i[2:0];
      if (wr_param) param_reg <= avm_writedata_i[7:0];
    end
  end

  assign avm_waitrequest_o = waitreq_reg;
  assign avm_readdata_o    = rdata_reg;

  // modem pins pass two flops; s3 only serves the edge finder
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {rxc_s1, rxc_s2, rxc_s3} <= 3'h0;
      {rxd_s1, rxd_s2}         <= 2'h0;
    end else begin
      {rxc_s1, rxc_s2, rxc_s3} <= {rx_clk_i, rxc_s1, rxc_s2};
      {rxd_s1, rxd_s2}         <= {rx_data_i, rxd_s1};
    end
  end

  // ones run and leading zero; both wiped while disabled
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ones_reg      <= 3'h0;
      lead_zero_reg <= 1'b0;
    end else if (!rx_en) begin
      ones_reg      <= 3'h0;
      lead_zero_reg <= 1'b0;
    end else if (bit_en) begin
      ones_reg      <= rx_bit ? ((ones_reg == `ONES_MAX) ? ones_reg : ones_reg + 3'h1) : 3'h0;
      lead_zero_reg <= lead_zero_reg | ~rx_bit;
    end
  end

  // bits seen since enabling, saturating; lets the partial-flag check count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) en_bits_reg <= 4'h0;
    else if (!rx_en) en_bits_reg <= 4'h0;
    else if (bit_en && en_bits_reg != 4'(CB)) en_bits_reg <= en_bits_reg + 4'h1;
  end

  // framing, hunting and character count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      framed_reg <= 1'b0;
      hunt_reg   <= 1'b0;
      cnt_reg    <= 3'h0;
    end else if (!rx_en || abort_hit) begin
      framed_reg <= 1'b0;
      hunt_reg   <= 1'b0;
      cnt_reg    <= 3'h0;
    end else if (flag_hit) begin
      framed_reg <= 1'b1;
      hunt_reg   <= 1'b0;
      cnt_reg    <= 3'h0;
    end else begin
      if (sec_miss) hunt_reg <= 1'b1;
      if (data_bit) cnt_reg <= count_full ? 3'h0 : cnt_reg + 3'h1;
    end
  end

  // flag bits pass through here but never reach the buffer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) shift_reg <= 8'h00;
    else if (!rx_en) shift_reg <= 8'h00;
    else if (shift_en) shift_reg <= new_char;
  end

  // message state; a secondary address match raises active only,
  // the first delivered character then opens the message
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      msg_reg    <= 1'b0;
      active_reg <= 1'b0;
    end else if (!rx_en || abort_hit || flag_hit) begin
      msg_reg    <= 1'b0;
      active_reg <= 1'b0;
    end else if (first_char && (addr_ok || !secondary_station_mode)) begin
      msg_reg    <= ~secondary_station_mode;
      active_reg <= 1'b1;
    end else if (load_data) begin
      msg_reg    <= 1'b1;
    end
  end

  // receive buffer; the check snapshot is taken at each char boundary
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) buf_reg <= `BUF_RST;
    else if (close_hit) buf_reg <= {1'b1, 1'b0, 8'h00};
    else if (load_data) buf_reg <= {1'b0, ~msg_reg, new_char};
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) crc_snap_reg <= `CRC_INIT;
    else if (char_done) crc_snap_reg <= crc_next;
  end

  // sticky flags: hardware set wins over software clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_reg   <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      if (load_buf) ready_reg <= 1'b1;
      else if (buf_read) ready_reg <= 1'b0;
      if (load_buf && ready_reg) overrun_reg <= 1'b1;
      else if (clr_ovr) overrun_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      end_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (close_hit) end_reg <= 1'b1;
      else if (clr_end) end_reg <= 1'b0;
      if (close_hit && chk_en && crc_bad) err_reg <= 1'b1;
      else if (clr_err) err_reg <= 1'b0;
    end
  end

  property p_disabled_idle;
    @(posedge clk_i) disable iff (!arst_n_i)
    !rx_en |=> !framed_reg && !msg_reg && ones_reg == 3'h0 && cnt_reg == 3'h0;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("receiver state not held while disabled");

  property p_partial_flag;
    @(posedge clk_i) disable iff (!arst_n_i)
    flag_hit |-> en_bits_reg >= 4'(CB - 1);
  endproperty
  a_partial_flag: assert property (p_partial_flag)
    else $error("flag recognized before eight bits after enabling");

  property p_flag_frames;
    @(posedge clk_i) disable iff (!arst_n_i)
    flag_hit |=> framed_reg && cnt_reg == 3'h0;
  endproperty
  a_flag_frames: assert property (p_flag_frames)
    else $error("flag did not frame the receiver");

  property p_stuff_drop;
    @(posedge clk_i) disable iff (!arst_n_i)
    bit_en && stuffed |=> $stable(shift_reg) && $stable(cnt_reg);
  endproperty
  a_stuff_drop: assert property (p_stuff_drop)
    else $error("inserted zero was clocked in");

  property p_load_char;
    @(posedge clk_i) disable iff (!arst_n_i)
    load_data |=> ready_reg && buf_reg[7:0] == $past(new_char) && !buf_reg[`BUF_EOM_BIT];
  endproperty
  a_load_char: assert property (p_load_char)
    else $error("character not loaded with ready set");

  property p_som;
    @(posedge clk_i) disable iff (!arst_n_i)
    load_data && !msg_reg |=> buf_reg[`BUF_SOM_BIT] && msg_reg && active_reg;
  endproperty
  a_som: assert property (p_som)
    else $error("first character lacks start-of-message");

  property p_read_clears;
    @(posedge clk_i) disable iff (!arst_n_i)
    buf_read && !load_buf |=> !ready_reg;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("buffer read did not clear ready");

  property p_overrun;
    @(posedge clk_i) disable iff (!arst_n_i)
    load_buf && ready_reg |=> overrun_reg;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("reload over unread character missed overrun");

  property p_no_overrun;
    @(posedge clk_i) disable iff (!arst_n_i)
    load_buf && !ready_reg && !overrun_reg |=> !overrun_reg;
  endproperty
  a_no_overrun: assert property (p_no_overrun)
    else $error("load into empty buffer raised overrun");

  property p_sec_withhold;
    @(posedge clk_i) disable iff (!arst_n_i)
    sec_match |=> active_reg && !msg_reg && $stable(buf_reg) && !$rose(ready_reg);
  endproperty
  a_sec_withhold: assert property (p_sec_withhold)
    else $error("secondary address was delivered");

  property p_close;
    @(posedge clk_i) disable iff (!arst_n_i)
    close_hit |=> buf_reg[`BUF_EOM_BIT] && end_reg && !msg_reg && !active_reg && framed_reg;
  endproperty
  a_close: assert property (p_close)
    else $error("closing flag handling wrong");

  property p_check_err;
    @(posedge clk_i) disable iff (!arst_n_i)
    close_hit && chk_en && crc_bad |=> err_reg;
  endproperty
  a_check_err: assert property (p_check_err)
    else $error("bad check not flagged at closing flag");
endmodule : bit_sync_hdlc_receiver
`default_nettype wire

// ==== rtl/hdlc_rx_consts.svh ====
// constants for the bit-synchronous framed receiver
// assumes inclusion by bare name from the receiver sources
`ifndef HDLC_RX_CONSTS_SVH
`define HDLC_RX_CONSTS_SVH

// register byte offsets on the Avalon-MM slave
`define RX_OFF_CTRL   4'h0
`define RX_OFF_PARAM  4'h4
`define RX_OFF_STAT   4'h8
`define RX_OFF_BUF    4'hC

// control register fields
`define CTRL_EN_BIT   0
`define CTRL_SEC_BIT  1
`define CTRL_CHK_BIT  2
`define CTRL_RST      3'h0
`define PARAM_RST     8'h00

// status register fields
`define STAT_OVR_BIT  1
`define STAT_END_BIT  4
`define STAT_ERR_BIT  5

// receive buffer register fields
`define BUF_SOM_BIT   8
`define BUF_EOM_BIT   9
`define BUF_RST       10'h000

// line coding
`define CHAR_BITS     8
`define STUFF_ONES    3'h5
`define FLAG_ONES     3'h6
`define ONES_MAX      3'h7

// check register, reflected polynomial shifted lsb first
`define CRC_INIT      16'hFFFF
`define CRC_POLY      16'h8408
`define CRC_GOOD      16'hF0B8

`endif

// ==== rtl/hdlc_rx_pkg.sv ====
// types shared by the framed receiver files
// assumes nothing of its surroundings
package hdlc_rx_pkg;
  typedef logic [7:0]  char_t;
  typedef logic [15:0] crc_t;
  typedef logic [9:0]  rxbuf_t;
endpackage : hdlc_rx_pkg

// ==== rtl/rx_check_crc.sv ====
// serial check register for received frames, one bit per step
// assumes step_i and clear_i come from logic on clk_i
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_rx_consts.svh"

module rx_check_crc #(
  parameter hdlc_rx_pkg::crc_t POLY = `CRC_POLY,
  parameter hdlc_rx_pkg::crc_t INIT = `CRC_INIT
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         clear_i,
  input  wire logic         step_i,
  input  wire logic         bit_i,
  output hdlc_rx_pkg::crc_t crc_next_o
);
  hdlc_rx_pkg::crc_t crc_reg;
  hdlc_rx_pkg::crc_t shifted;
  wire               fb = crc_reg[0] ^ bit_i;

  assign shifted    = {1'b0, crc_reg[15:1]};
  assign crc_next_o = clear_i ? INIT : (step_i ? (fb ? shifted ^ POLY : shifted) : crc_reg);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) crc_reg <= `CRC_INIT;
    else crc_reg <= crc_next_o;
  end
endmodule : rx_check_crc
`default_nettype wire

// ==== verification/line_modem_model.sv ====
// serial source standing in for the synchronous modem on the receive line
// assumes the bench calls its tasks one at a time; the clock stands still between calls
`timescale 1ns/1ns
`default_nettype none
module line_modem_model (
  output logic rx_clk_o,
  output logic rx_data_o
);
  int ones;
  initial begin
    rx_clk_o  = 1'b0;
    rx_data_o = 1'b1;
    ones      = 0;
  end
  // data moves while the clock is low; a released line shows the inverse
  task automatic send_bit(input logic b);
    rx_data_o = b;
    #160 rx_clk_o = 1'b1;
    #160 rx_clk_o = 1'b0;
    rx_data_o = ~b;
  endtask : send_bit
  // unstuffed bits lsb first, used for flags, flag fragments, aborts and other raw bit patterns
  task automatic send_raw(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      send_bit(v[i]);
    end
    ones = 0;
  endtask : send_raw
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      send_bit(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (ones == 5) begin
        send_bit(1'b0);
        ones = 0;
      end
    end
  endtask : send_byte
endmodule : line_modem_model
`default_nettype wire

// ==== verification/bit_sync_hdlc_receiver_tb.sv ====
// self-checking bench for the framed serial receiver
// assumes the modem model drives the line and the tasks here drive the register bus
`timescale 1ns/1ns
`default_nettype none
module bit_sync_hdlc_receiver_tb;
  typedef struct {logic [7:0] ch; logic [9:0] e;} row_t;
  logic        clk_i;
  logic        arst_n_i;
  logic [3:0]  avm_address_i;
  logic        avm_read_i;
  logic        avm_write_i;
  logic [31:0] avm_writedata_i;
  logic [3:0]  avm_byteenable_i;
  logic [31:0] avm_readdata_o;
  logic        avm_waitrequest_o;
  logic        rx_clk_i;
  logic        rx_data_i;
  logic [31:0] q;
  logic [15:0] crc;
  int          mismatches       = 0;
  int          n_checks         = 0;
  row_t        rows [4]         = '{'{8'h5A, 10'h15A}, '{8'h3F, 10'h03F},
                                    '{8'hFF, 10'h0FF}, '{8'h7E, 10'h07E}};
  always #20 clk_i = ~clk_i;
  bit_sync_hdlc_receiver dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avm_address_i(avm_address_i),
    .avm_read_i(avm_read_i), .avm_write_i(avm_write_i),
    .avm_writedata_i(avm_writedata_i), .avm_byteenable_i(avm_byteenable_i),
    .avm_readdata_o(avm_readdata_o), .avm_waitrequest_o(avm_waitrequest_o),
    .rx_clk_i(rx_clk_i), .rx_data_i(rx_data_i));
  line_modem_model mdm_u (.rx_clk_o(rx_clk_i), .rx_data_o(rx_data_i));
  task automatic conclude();
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    avm_address_i    <= a;
    avm_writedata_i  <= d;
    avm_byteenable_i <= be;
    avm_write_i      <= w;
    avm_read_i       <= ~w;
    @(posedge clk_i);
    while (avm_waitrequest_o !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 20) begin
      mismatches++;
      $display("mismatch waitrequest expected 0 seen 1");
    end
    r = avm_readdata_o;
    avm_write_i <= 1'b0;
    avm_read_i  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'hF, r);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 4'hF, r);
    chk(nm, e, r);
  endtask : rd_chk
  // lets the synchronised line edge reach the registers
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask : settle
  task automatic char_rx(input logic [7:0] v, input logic [9:0] e);
    mdm_u.send_byte(v);
    settle();
    rd_chk("stat", 4'h8, 32'h4D);
    rd_chk("buf", 4'hC, {22'h0, e});
    rd_chk("stat", 4'h8, 32'h4C);
  endtask : char_rx
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ v[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return c;
  endfunction : crc8
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  initial begin
    clk_i            = 1'b0;
    arst_n_i         = 1'b0;
    avm_address_i    = 4'h0;
    avm_read_i       = 1'b0;
    avm_write_i      = 1'b0;
    avm_writedata_i  = 32'h0;
    avm_byteenable_i = 4'hF;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_chk("ctrl", 4'h0, 32'h0);
    rd_chk("stat", 4'h8, 32'h0);
    rd_chk("buf", 4'hC, 32'h0);
    wr(4'h2, 32'hFF);
    rd_chk("unmapped", 4'h2, 32'h0);
    mdm_u.send_raw(8'h7E, 8);
    mdm_u.send_byte(8'h11);
    settle();
    rd_chk("stat", 4'h8, 32'h0);
    mdm_u.send_raw(8'h7E, 1);
    wr(4'h0, 32'h5);
    mdm_u.send_raw(8'h3F, 7);
    settle();
    rd_chk("stat", 4'h8, 32'h0);
    repeat (2) mdm_u.send_raw(8'h7E, 8);
    settle();
    rd_chk("stat", 4'h8, 32'h40);
    wr(4'h4, 32'h5A);
    bus(1'b1, 4'h4, 32'hA5, 4'h0, q);
    rd_chk("param", 4'h4, 32'h5A);
    crc = 16'hFFFF;
    foreach (rows[i]) begin
      char_rx(rows[i].ch, rows[i].e);
      crc = crc8(crc, rows[i].ch);
    end
    crc = ~crc;
    char_rx(crc[7:0], {2'b00, crc[7:0]});
    char_rx(crc[15:8], {2'b00, crc[15:8]});
    mdm_u.send_raw(8'h7E, 8);
    settle();
    rd_chk("stat", 4'h8, 32'h51);
    rd_chk("buf", 4'hC, 32'h200);
    wr(4'h8, 32'h32);
    mdm_u.send_raw(8'h7E, 8);
    mdm_u.send_byte(8'h01);
    settle();
    rd_chk("stat", 4'h8, 32'h4D);
    mdm_u.send_byte(8'h02);
    mdm_u.send_raw(8'h7E, 8);
    settle();
    rd_chk("stat", 4'h8, 32'h73);
    rd_chk("buf", 4'hC, 32'h200);
    wr(4'h8, 32'h32);
    wr(4'h0, 32'h3);
    mdm_u.send_raw(8'h7E, 8);
    mdm_u.send_byte(8'h33);
    mdm_u.send_byte(8'h44);
    settle();
    rd_chk("stat", 4'h8, 32'h40);
    mdm_u.send_raw(8'h7E, 8);
    mdm_u.send_byte(8'h5A);
    settle();
    rd_chk("stat", 4'h8, 32'h44);
    mdm_u.send_byte(8'h11);
    settle();
    rd_chk("buf", 4'hC, 32'h111);
    mdm_u.send_raw(8'h22, 4);
    wr(4'h0, 32'h0);
    mdm_u.send_raw(8'h22, 8);
    settle();
    rd_chk("stat", 4'h8, 32'h0);
    rd_chk("buf", 4'hC, 32'h111);
    wr(4'h0, 32'h1);
    mdm_u.send_raw(8'h7E, 8);
    mdm_u.send_byte(8'h55);
    mdm_u.send_raw(8'hFF, 8);
    settle();
    rd_chk("stat", 4'h8, 32'h1);
    rd_chk("buf", 4'hC, 32'h155);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_chk("ctrl", 4'h0, 32'h0);
    rd_chk("buf", 4'hC, 32'h0);
    conclude();
  end
endmodule : bit_sync_hdlc_receiver_tb
`default_nettype wire
